/* File: txbd_dma.sv */
// Purpose: Transmit DMA channel that walks descriptor chains and feeds an endpoint FIFO.
// Assumes: Memory answers each held request with one mem_ack_i pulse.
// Notes: One byte per memory read keeps byte alignment trivial at the cost of bandwidth.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module txbd_dma #(
    parameter int unsigned REG_AW = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [REG_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Memory master.
    output txbd_pkg::txbd_mem_req_t mem_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    // Byte stream to the endpoint FIFO.
    output txbd_pkg::txbd_tx_t tx_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    // Interrupt and state.
    output logic irq_o,
    output logic busy_o
);
    // Wider addresses would be cut to eight bits and alias the register map.
    if (REG_AW < 5 || REG_AW > 8) begin : g_chk
        $error("REG_AW must cover the register map without aliasing");
    end

    typedef enum logic [3:0] {S_IDLE, S_DRD, S_DEC, S_FETCH, S_SEND, S_ZLP, S_END, S_EOQ, S_OWN} txbd_st_t;

    txbd_st_t st_r, st_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [31:0] cur_r, cur_nxt, w0_r, w0_nxt, w1_r, w1_nxt, w2_r, w2_nxt, w3_r, w3_nxt;
    logic [31:0] sop_adr_r, sop_adr_nxt, sop_w3_r, sop_w3_nxt, ptr_r, ptr_nxt;
    logic [15:0] rem_r, rem_nxt, bcnt_r, bcnt_nxt;
    logic eoq_r, eoq_nxt;
    txbd_pkg::txbd_mem_req_t mem_r, mem_nxt;
    txbd_pkg::txbd_tx_t tx_r, tx_nxt;
    logic txv_r, txv_nxt;
    logic en_r, en_nxt, ack_r, ack_nxt;
    logic [31:0] head_r, head_nxt, comp_r, comp_nxt, rdat_r, rdat_nxt;
    logic [2:0] stat_r, stat_nxt, mask_r, mask_nxt, st_set;
    logic [31:0] wmask;
    logic wr_go;
    logic [7:0] radr;

    assign wb_dat_o = rdat_r;
    assign wb_ack_o = ack_r;
    assign mem_o = mem_r;
    assign tx_o = tx_r;
    assign tx_valid_o = txv_r;
    assign irq_o = |(stat_r & mask_r);
    assign busy_o = (st_r != S_IDLE);
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_r; // A write lands at the edge that completes the cycle.
    assign radr = 8'(wb_adr_i);

    // Register slave: one wait state, unmapped offsets read zero and ignore writes.
    always_comb begin
        ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
        en_nxt = en_r;
        mask_nxt = mask_r;
        head_nxt = head_r;
        rdat_nxt = rdat_r;
        // Hardware set wins over a write-one clear in the same cycle.
        stat_nxt = stat_r | st_set;
        if (wr_go) begin
            unique case (radr)
                txbd_pkg::REG_CTRL: en_nxt = wb_sel_i[0] ? wb_dat_i[0] : en_r;
                txbd_pkg::REG_HEAD: begin
                    // A new head is taken only while idle so a live walk is never torn.
                    if (st_r == S_IDLE) begin
                        head_nxt = (head_r & ~wmask) | (wb_dat_i & wmask);
                    end
                end
                txbd_pkg::REG_STAT: stat_nxt = (stat_r & ~(wb_dat_i[2:0] & wmask[2:0])) | st_set;
                txbd_pkg::REG_MASK: mask_nxt = (mask_r & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
                default: ;
            endcase
        end
        if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r) begin
            unique case (radr)
                txbd_pkg::REG_CTRL: rdat_nxt = {31'h0, en_r};
                txbd_pkg::REG_HEAD: rdat_nxt = head_r;
                txbd_pkg::REG_STAT: rdat_nxt = {29'h0, stat_r};
                txbd_pkg::REG_MASK: rdat_nxt = {29'h0, mask_r};
                txbd_pkg::REG_COMP: rdat_nxt = comp_r;
                default: rdat_nxt = 32'h0;
            endcase
        end
        // A drained queue or a stopped walk drops the head, so the walker never spins on a bad chain.
        if ((st_r == S_OWN && mem_r.cyc && mem_ack_i && w0_r == 32'h0) || st_set[txbd_pkg::ST_STOP]) begin
            head_nxt = 32'h0;
        end
    end

    // Descriptor walker.
    always_comb begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        cur_nxt = cur_r;
        w0_nxt = w0_r;
        w1_nxt = w1_r;
        w2_nxt = w2_r;
        w3_nxt = w3_r;
        sop_adr_nxt = sop_adr_r;
        sop_w3_nxt = sop_w3_r;
        ptr_nxt = ptr_r;
        rem_nxt = rem_r;
        bcnt_nxt = bcnt_r;
        eoq_nxt = eoq_r;
        mem_nxt = mem_r;
        tx_nxt = tx_r;
        txv_nxt = txv_r;
        comp_nxt = comp_r;
        st_set = 3'h0;
        unique case (st_r)
            S_IDLE: begin
                if (en_r && head_r != 32'h0 && !wr_go) begin
                    cur_nxt = head_r;
                    idx_nxt = 2'h0;
                    rem_nxt = 16'h0;
                    st_nxt = S_DRD;
                end
            end
            S_DRD: begin
                // All four words are in hand before any buffer access.
                mem_nxt.cyc = 1'b1;
                mem_nxt.we = 1'b0;
                mem_nxt.adr = cur_r + {28'h0, idx_r, 2'b00};
                if (mem_r.cyc && mem_ack_i) begin
                    mem_nxt.cyc = 1'b0;
                    unique case (idx_r)
                        2'h0: w0_nxt = mem_rdata_i;
                        2'h1: w1_nxt = mem_rdata_i;
                        2'h2: w2_nxt = mem_rdata_i;
                        2'h3: w3_nxt = mem_rdata_i;
                    endcase
                    idx_nxt = idx_r + 2'h1;
                    if (idx_r == 2'h3) begin
                        st_nxt = S_DEC;
                    end
                end
            end
            S_DEC: begin
                // Length excludes skipped bytes; the offset counts only on a first buffer.
                ptr_nxt = w1_r;
                bcnt_nxt = w2_r[txbd_pkg::LEN_MSB:txbd_pkg::LEN_LSB];
                st_nxt = w3_r[txbd_pkg::ZERO_BIT] ? S_ZLP : S_FETCH;
                if (w3_r[txbd_pkg::FIRST_BIT]) begin
                    ptr_nxt = w1_r + {16'h0, w2_r[txbd_pkg::OFS_MSB:txbd_pkg::OFS_LSB]};
                    rem_nxt = w3_r[txbd_pkg::LEN_MSB:txbd_pkg::LEN_LSB];
                    sop_adr_nxt = cur_r;
                    sop_w3_nxt = w3_r;
                    // A packet software still holds is never sent.
                    if (!w3_r[txbd_pkg::OWN_BIT]) begin
                        st_set[txbd_pkg::ST_STOP] = 1'b1;
                        st_nxt = S_IDLE;
                    end
                end
                if (w3_r[txbd_pkg::ZERO_BIT]) begin
                    tx_nxt = '{data: 8'h00, last: 1'b1, zlp: 1'b1};
                end
            end
            S_FETCH: begin
                // Once the packet length is spent the rest of the chain is walked, not read.
                if (bcnt_r == 16'h0 || rem_r == 16'h0) begin
                    st_nxt = S_END;
                end else begin
                    mem_nxt.cyc = 1'b1;
                    mem_nxt.we = 1'b0;
                    mem_nxt.adr = {ptr_r[31:2], 2'b00};
                    if (mem_r.cyc && mem_ack_i) begin
                        mem_nxt.cyc = 1'b0;
                        tx_nxt.data = mem_rdata_i[{ptr_r[1:0], 3'b000} +: 8];
                        tx_nxt.zlp = 1'b0;
                        tx_nxt.last = (rem_r == 16'h1) || (w3_r[txbd_pkg::LAST_BIT] && bcnt_r == 16'h1);
                        txv_nxt = 1'b1;
                        st_nxt = S_SEND;
                    end
                end
            end
            S_SEND: begin
                if (tx_ready_i) begin
                    txv_nxt = 1'b0;
                    ptr_nxt = ptr_r + 32'h1;
                    bcnt_nxt = bcnt_r - 16'h1;
                    rem_nxt = rem_r - 16'h1;
                    st_nxt = S_FETCH;
                end
            end
            S_ZLP: begin
                txv_nxt = 1'b1;
                if (txv_r && tx_ready_i) begin
                    txv_nxt = 1'b0;
                    st_nxt = S_END;
                end
            end
            S_END: begin
                // Buffer end closes the queue, returns the packet, follows the next pointer, or stops on a chain cut mid-packet.
                eoq_nxt = (w0_r == 32'h0);
                idx_nxt = 2'h0;
                if (w3_r[txbd_pkg::LAST_BIT]) begin
                    st_nxt = (w0_r == 32'h0) ? S_EOQ : S_OWN;
                end else if (w0_r == 32'h0) begin
                    st_set[txbd_pkg::ST_STOP] = 1'b1;
                    st_nxt = S_IDLE;
                end else begin
                    cur_nxt = w0_r;
                    st_nxt = S_DRD;
                end
            end
            S_EOQ: begin
                // Only the drained bit changes; reserved fields go back as read.
                mem_nxt = '{cyc: 1'b1, we: 1'b1, adr: cur_r + txbd_pkg::W3_BYTE_OFS, dat: w3_r};
                mem_nxt.dat[txbd_pkg::DRAINED_BIT] = 1'b1;
                if (mem_r.cyc && mem_ack_i) begin
                    mem_nxt.cyc = 1'b0;
                    st_nxt = S_OWN;
                end
            end
            S_OWN: begin
                // Hand the packet back; a single-buffer packet keeps its drained bit.
                mem_nxt = '{cyc: 1'b1, we: 1'b1, adr: sop_adr_r + txbd_pkg::W3_BYTE_OFS, dat: sop_w3_r};
                mem_nxt.dat[txbd_pkg::OWN_BIT] = 1'b0;
                if (eoq_r && sop_adr_r == cur_r) begin
                    mem_nxt.dat[txbd_pkg::DRAINED_BIT] = 1'b1;
                end
                if (mem_r.cyc && mem_ack_i) begin
                    mem_nxt.cyc = 1'b0;
                    comp_nxt = cur_r;
                    st_set[txbd_pkg::ST_PKT] = 1'b1;
                    st_set[txbd_pkg::ST_DRAIN] = eoq_r;
                    cur_nxt = w0_r;
                    st_nxt = eoq_r ? S_IDLE : S_DRD;
                end
            end
        endcase
    end

    // State registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= S_IDLE;
            idx_r <= 2'h0;
            cur_r <= 32'h0;
            w0_r <= 32'h0;
            w1_r <= 32'h0;
            w2_r <= 32'h0;
            w3_r <= 32'h0;
            sop_adr_r <= 32'h0;
            sop_w3_r <= 32'h0;
            ptr_r <= 32'h0;
            rem_r <= 16'h0;
            bcnt_r <= 16'h0;
            eoq_r <= 1'b0;
            mem_r <= '0;
            tx_r <= '0;
            txv_r <= 1'b0;
            en_r <= 1'b0;
            ack_r <= 1'b0;
            head_r <= 32'h0;
            comp_r <= 32'h0;
            rdat_r <= 32'h0;
            stat_r <= 3'h0;
            mask_r <= txbd_pkg::MASK_RST;
        end else begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            cur_r <= cur_nxt;
            w0_r <= w0_nxt;
            w1_r <= w1_nxt;
            w2_r <= w2_nxt;
            w3_r <= w3_nxt;
            sop_adr_r <= sop_adr_nxt;
            sop_w3_r <= sop_w3_nxt;
            ptr_r <= ptr_nxt;
            rem_r <= rem_nxt;
            bcnt_r <= bcnt_nxt;
            eoq_r <= eoq_nxt;
            mem_r <= mem_nxt;
            tx_r <= tx_nxt;
            txv_r <= txv_nxt;
            en_r <= en_nxt;
            ack_r <= ack_nxt;
            head_r <= head_nxt;
            comp_r <= comp_nxt;
            rdat_r <= rdat_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    desc_fetch_a: assert property (st_r == S_DRD && mem_r.cyc |-> mem_r.adr == cur_r + {28'h0, idx_r, 2'b00})
        else $error("descriptor word address wrong");
    skip_offset_a: assert property (st_r == S_DEC && w3_r[31] && w3_r[29] |=> ptr_r == $past(w1_r) + {16'h0, $past(w2_r[31:16])})
        else $error("leading offset not applied");
    zlp_nofetch_a: assert property (txv_r && tx_r.zlp |-> !mem_r.cyc)
        else $error("zero-length packet fetched data");
    trunc_len_a: assert property (txv_r && !tx_r.zlp |-> rem_r != 16'h0 && bcnt_r != 16'h0)
        else $error("byte sent beyond packet length");
    last_byte_a: assert property (st_r == S_SEND && rem_r == 16'h1 |-> tx_r.last)
        else $error("final byte not marked last");
    own_clear_a: assert property (st_r == S_OWN && mem_r.cyc |-> mem_r.we && !mem_r.dat[29] && mem_r.dat[31])
        else $error("ownership not returned");
    drained_set_a: assert property (st_r == S_EOQ && mem_r.cyc |-> mem_r.dat[28] && w0_r == 32'h0)
        else $error("drained flag wrong");
    reserved_keep_a: assert property (st_r == S_EOQ && mem_r.cyc |-> mem_r.dat[27:24] == w3_r[27:24] && mem_r.dat[22:16] == w3_r[22:16])
        else $error("reserved bits altered");
    next_follow_a: assert property (st_r == S_OWN && mem_ack_i && !eoq_r |=> st_r == S_DRD && cur_r == $past(w0_r))
        else $error("next pointer not followed");
    wb_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule : txbd_dma

/* File: txbd_pkg.sv */
// Purpose: Constants and carrier types for the transmit buffer descriptor walker.
// Assumes: Descriptors are four little-endian 32-bit words in main memory.
// Notes: Register offsets are byte addresses on the classic Wishbone slave port.
// Contract
// - Word two bits 31:16 give leading bytes to skip before valid data.
// - Word two bits 15:0 count valid buffer bytes, skipped bytes excluded.
// - Word three bit 31 set marks the first buffer of a packet.
// - Word three bit 30 set marks the final buffer of a packet.
// - Word three bit 29 ownership: software sets it, engine clears after sending.
// - Engine sets word three bit 28 on the last descriptor of the drained queue.
// - Word three bit 23 set sends a zero-length packet and fetches no data.
// - First descriptor word three bits 15:0 is packet length; extra data dropped.
// - All four first/last flag combinations are handled.
// - Word zero is the next descriptor address; zero ends the queue.
// - Word one is the byte address of the descriptor's data buffer.
// - Descriptors are four aligned words, all fetched before the buffer is used.
package txbd_pkg;
    // Descriptor layout.
    localparam int DESC_WORDS = 4;
    localparam logic [31:0] W3_BYTE_OFS = 32'h0000000c;
    localparam int FIRST_BIT = 31;
    localparam int LAST_BIT = 30;
    localparam int OWN_BIT = 29;
    localparam int DRAINED_BIT = 28;
    localparam int ZERO_BIT = 23;
    localparam int OFS_MSB = 31;
    localparam int OFS_LSB = 16;
    localparam int LEN_MSB = 15;
    localparam int LEN_LSB = 0;
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_HEAD = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0c;
    localparam logic [7:0] REG_COMP = 8'h10;
    // Status bits: packet sent, queue drained, walk stopped on a bad chain.
    localparam int ST_PKT = 0;
    localparam int ST_DRAIN = 1;
    localparam int ST_STOP = 2;
    localparam int ST_W = 3;
    localparam logic [2:0] MASK_RST = 3'h0;
    // Memory master request, held until acknowledged.
    typedef struct packed {
        logic cyc;
        logic we;
        logic [31:0] adr;
        logic [31:0] dat;
    } txbd_mem_req_t;
    // One entry towards the endpoint FIFO.
    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic zlp;
    } txbd_tx_t;
endpackage : txbd_pkg

/* File: txbd_mem_model.sv */
// Purpose: Main memory model that answers the walker's word reads and writes.
// Assumes: Address bits 9:2 pick one of 256 words, which holds every test chain.
// Notes: Read data turns to noise between answers so a stale word never passes as valid.
`timescale 1ns/1ps
module txbd_mem_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Request side.
    input wire txbd_pkg::txbd_mem_req_t req_i,
    input wire logic slow_i,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [0:255];
    logic [1:0] wait_r;

    // Answer each held request once; a slow answer costs at most two extra cycles.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wait_r <= 2'h0;
            ack_o <= 1'b0;
            rdata_o <= 32'h5a5a5a5a;
        end else if (req_i.cyc && !ack_o && !(slow_i && wait_r != 2'h2)) begin
            wait_r <= 2'h0;
            ack_o <= 1'b1;
            if (req_i.we) mem[req_i.adr[9:2]] <= req_i.dat;
            rdata_o <= req_i.we ? ~rdata_o : mem[req_i.adr[9:2]];
        end else begin
            // A held request that is made to wait counts towards its answer.
            if (req_i.cyc && !ack_o) wait_r <= wait_r + 2'h1;
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o;
        end
    end
endmodule : txbd_mem_model

/* File: tx_buffer_descriptor_decode_bench.sv */
// Purpose: Self-checking bench for the descriptor-driven transmit channel.
// Assumes: Memory answers with random latency and the endpoint stalls at random.
// Notes: Expected bytes come from the model memory, never from the walker.
`timescale 1ns/1ps
module tx_buffer_descriptor_decode_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, tx_ready = 1'b0, slow = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dw = 32'h0, wb_dr, mem_rdata, rd, r;
    logic wb_ack, mem_ack, tx_valid, irq, busy;
    txbd_pkg::txbd_mem_req_t mem_req;
    txbd_pkg::txbd_tx_t tx;
    txbd_pkg::txbd_tx_t exp_q[$];
    int n_fail = 0, compares = 0, cycles = 0;
    logic [31:0] seed = 32'd12915;
    localparam logic [31:0] ZBUF = 32'h000003f0;

    txbd_dma DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dw), .wb_dat_o(wb_dr), .wb_ack_o(wb_ack),
        .mem_o(mem_req), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata), .tx_o(tx), .tx_valid_o(tx_valid),
        .tx_ready_i(tx_ready), .irq_o(irq), .busy_o(busy));
    txbd_mem_model MEM (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req), .slow_i(slow), .ack_o(mem_ack),
        .rdata_o(mem_rdata));

    // Free-running 20 MHz clock.
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (n_fail == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    // Classic single cycle; the request stays put until ack is sampled high.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dw <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        rd = wb_dr;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    task automatic desc(input logic [31:0] at, nxt, buf_a, w2, w3);
        MEM.mem[at[9:2]] = nxt;
        MEM.mem[at[9:2] + 8'h1] = buf_a;
        MEM.mem[at[9:2] + 8'h2] = w2;
        MEM.mem[at[9:2] + 8'h3] = w3;
    endtask : desc

    task automatic expect_bytes(input logic [31:0] a, input int n, input logic fin);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(txbd_pkg::txbd_tx_t'({MEM.mem[8'((a + i) >> 2)][8 * ((a + i) % 4) +: 8],
                fin && i == n - 1, 1'b0}));
        end
    endtask : expect_bytes

    // Start a walk and wait until the walker is idle and every byte was seen.
    task automatic run(input logic [31:0] head);
        wb(1'b1, txbd_pkg::REG_HEAD, head);
        while (busy !== 1'b1) @(posedge clk_i);
        while (busy !== 1'b0 || exp_q.size() != 0) @(posedge clk_i);
    endtask : run

    // Random stalls on both sides, and a ceiling on the run length.
    always @(posedge clk_i) begin
        r = rnd();
        tx_ready <= r[0] | r[1];
        slow <= r[2];
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end

    // Each byte taken by the endpoint is matched against the oldest note.
    always @(posedge clk_i) begin
        if (!rst_i && tx_valid === 1'b1 && tx_ready) begin
            if (exp_q.size() == 0) check(32'(tx), 32'h3ff);
            else check(32'(tx), 32'(exp_q.pop_front()));
        end
        if (mem_req.cyc === 1'b1 && !mem_req.we && mem_req.adr[31:4] == ZBUF[31:4]) check(mem_req.adr, 32'h0);
    end

    // Main sequence.
    initial begin
        for (int i = 0; i < 256; i++) MEM.mem[i] = rnd();
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, txbd_pkg::REG_MASK, 32'h0);
        check(rd, 32'(txbd_pkg::MASK_RST));
        wb(1'b1, 8'h20, 32'hffffffff);
        wb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, txbd_pkg::REG_CTRL, 32'h1);
        wb(1'b1, txbd_pkg::REG_MASK, 32'h7);
        // Single-buffer packet with leading bytes skipped; reserved bits must survive.
        desc(32'h50, 32'h0, 32'h101, {16'd3, 16'd5}, 32'hea550005);
        expect_bytes(32'h104, 5, 1'b1);
        run(32'h50);
        check(MEM.mem[8'h17], 32'hda550005);
        wb(1'b0, txbd_pkg::REG_COMP, 32'h0);
        check(rd, 32'h50);
        wb(1'b0, txbd_pkg::REG_HEAD, 32'h0);
        check(rd, 32'h0);
        check(32'(irq), 32'h1);
        // Sticky status clears per bit and the mask gates the interrupt; a write shows one edge after its ack.
        wb(1'b1, txbd_pkg::REG_STAT, 32'h1);
        wb(1'b0, txbd_pkg::REG_STAT, 32'h0);
        check(rd, 32'h2);
        wb(1'b1, txbd_pkg::REG_MASK, 32'h1);
        @(posedge clk_i);
        check(32'(irq), 32'h0);
        wb(1'b1, txbd_pkg::REG_STAT, 32'h2);
        wb(1'b1, txbd_pkg::REG_MASK, 32'h7);
        @(posedge clk_i);
        check(32'(irq), 32'h0);
        // Three-buffer packet truncated by its length, then a zero-byte packet.
        desc(32'h10, 32'h20, 32'h140, {16'd1, 16'd3}, 32'ha0000007);
        desc(32'h20, 32'h30, 32'h180, {16'd0, 16'd2}, 32'h0);
        desc(32'h30, 32'h40, 32'h1c0, {16'd0, 16'd4}, 32'h40000000);
        desc(32'h40, 32'h0, ZBUF, 32'h0, 32'he0800000);
        expect_bytes(32'h141, 3, 1'b0);
        expect_bytes(32'h180, 2, 1'b0);
        expect_bytes(32'h1c0, 2, 1'b1);
        exp_q.push_back(txbd_pkg::txbd_tx_t'({8'h00, 1'b1, 1'b1}));
        run(32'h10);
        check(MEM.mem[8'h07], 32'h80000007);
        check(MEM.mem[8'h0f], 32'h40000000);
        check(MEM.mem[8'h13], 32'hd0800000);
        wb(1'b0, txbd_pkg::REG_COMP, 32'h0);
        check(rd, 32'h40);
        wb(1'b0, txbd_pkg::REG_STAT, 32'h0);
        check(rd, 32'h3);
        // A first buffer that software still owns stops the walk: no byte goes out, nothing is written back.
        wb(1'b1, txbd_pkg::REG_STAT, 32'h7);
        desc(32'h60, 32'h0, 32'h200, {16'd0, 16'd1}, 32'hc0000001);
        run(32'h60);
        check(MEM.mem[8'h1b], 32'hc0000001);
        wb(1'b0, txbd_pkg::REG_STAT, 32'h0);
        check(rd, 32'h4);
        check(32'(irq), 32'h1);
        wb(1'b0, txbd_pkg::REG_HEAD, 32'h0);
        check(rd, 32'h0);
        conclude();
    end
endmodule : tx_buffer_descriptor_decode_bench
